// ### shared/slwc_pkg.sv
// shared constants, codes and decode helper for the serial link word codec
package slwc_pkg;
    localparam int         W_BITS       = 16;              // word field width
    localparam int         C_BITS       = 4;               // coding field width
    localparam int         WORD_BITS    = 20;              // encoded word width
    localparam int         CTRL_BITS    = 14;              // payload of a control word
    localparam logic [4:0] WORD_LAST    = 5'h13;           // last bit index of a word
    localparam logic [4:0] WORD_HALF    = 5'h0A;           // word clock high for bits 0..9
    localparam int         FLAG_WINDOW  = 32;              // words without flag transition
    localparam int         READY_WORDS  = 64;              // quiet words before ready
    localparam int         READY_MAX    = 128;             // upper bound of the ready wait
    localparam logic [1:0] ERR_SLIP_CNT = 2'h2;            // consecutive errors before a slip
    localparam logic [2:0] REF_LOCK_CNT = 3'h4;            // reference edges before freq lock
    // rate range select codes, identical at both ends of the link
    localparam logic [1:0] RATE_DIV1    = 2'h0;            // one bit per clock
    localparam logic [1:0] RATE_DIV2    = 2'h1;            // one bit per two clocks
    localparam logic [1:0] RATE_DIV4    = 2'h2;            // one bit per four clocks
    localparam logic [1:0] RATE_BYPASS  = 2'h3;            // receiver: test clock bypass
    // coding field patterns; the inverted forms are their complements
    localparam logic [3:0] C_DATA0      = 4'hC;            // data word, flag low
    localparam logic [3:0] C_DATA1      = 4'hE;            // data word, flag high
    localparam logic [3:0] C_CTRL       = 4'hB;            // control word
    localparam logic [3:0] C_IDLE       = 4'h8;            // idle word
    localparam logic [1:0] CTRL_MARK    = 2'h1;            // top bits of a control word field
    localparam logic [15:0] IDLE_W      = 16'h00FF;        // idle word field, balanced
    // flag scrambler: x^7 + x^6 + 1
    localparam int         SCR_W        = 7;               // scrambler length
    localparam int         SCR_TAP_A    = 6;               // first tap
    localparam int         SCR_TAP_B    = 5;               // second tap
    localparam logic [6:0] SCR_SEED     = 7'h5A;           // nonzero start state

    typedef enum logic [1:0] {K_IDLE, K_DATA, K_CTRL, K_ERR} slwc_kind_e;

    // classify an un-inverted coding field
    function automatic slwc_kind_e slwc_classify(input logic [3:0] c);
        slwc_kind_e k;
        k = K_ERR;
        if (c == C_DATA0 || c == C_DATA1) begin
            k = K_DATA;
        end else if (c == C_CTRL) begin
            k = K_CTRL;
        end else if (c == C_IDLE) begin
            k = K_IDLE;
        end
        return k;
    endfunction

    // true when a coding field is one of the inverted patterns
    function automatic logic slwc_is_inv(input logic [3:0] c);
        return (c == ~C_DATA0) || (c == ~C_DATA1) || (c == ~C_CTRL) || (c == ~C_IDLE);
    endfunction
endpackage

// ### logic/slwc_flag_scrambler.sv
// self-synchronising flag scrambler or descrambler, one step per data word
`timescale 1ns/1ns
module slwc_flag_scrambler #(
    parameter bit DESCRAMBLE = 1'b0,                   // 1: descramble received bits
    parameter int LFSR_W     = slwc_pkg::SCR_W         // history length
) (
    input  wire logic core_clk_i,                      // core clock
    input  wire logic resetn_i,                        // async reset, active low
    input  wire logic step_i,                          // advance one data word
    input  wire logic bit_i,                           // plain or scrambled flag in
    output logic      bit_o                            // scrambled or plain flag out
);
    import slwc_pkg::*;

    typedef struct packed {
        logic [LFSR_W-1:0] sr;                         // last flag bits on the line
    } slwc_scr_s;

    slwc_scr_s q;                                      // registered state
    slwc_scr_s d;                                      // next state

    // elaboration check: taps are fixed, so the length is too
    if (LFSR_W <= SCR_TAP_A || LFSR_W != SCR_W) begin : g_bad_len
        $error("scrambler length must match the tap set");
    end

    // feedback taps the line history, so the descrambler locks by itself
    always_comb begin
        d     = q;
        bit_o = bit_i ^ q.sr[SCR_TAP_A] ^ q.sr[SCR_TAP_B];
        if (step_i) begin
            // history always holds what travels on the line
            d.sr = {q.sr[LFSR_W-2:0], DESCRAMBLE ? bit_i : bit_o};
        end
    end

    // state register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q.sr <= LFSR_W'(SCR_SEED);
        end else begin
            q <= d;
        end
    end
endmodule

// ### logic/slwc_codec.sv
// serial link word codec: encoder, serializer, deserializer, decoder, aligner
`timescale 1ns/1ns
// Contract
// - both ends share one rate range code
// - lock to word clock, 20 bits per word
// - bypass uses word clock as bit clock
// - control select sends 14 bits, control code
// - data valid sends 16 bits, data code
// - otherwise send an idle word with a balanced word field
// - coding field from control, data, flag inputs
// - join code and word, send 20 bits
// - word disparity, running total kept
// - invert word when it restores balance
// - receiver keeps reference frequency lock
// - receive rate divides 1,2,4 or test clock
// - slip one bit per request, disable, reset
// - split received 20 bits into fields
// - classify word type, inversion, error, flag
// - two consecutive errors request a slip
// - enhanced mode: no flag transition in 32 words slips
// - ready after 64..127 quiet words, drops at once
// - descramble flag only in enhanced mode
// - alternating flag sent and checked when disabled; checked only outside enhanced mode
// - control words flagged, low 14 bits only
module slwc_codec #(
    parameter int READY_WORDS = slwc_pkg::READY_WORDS  // quiet words before ready
) (
    input  wire logic                         core_clk_i,                  // 50 MHz clock
    input  wire logic                         resetn_i,                    // async, active low
    input  wire logic                         tx_word_clock_i,             // word or bit clock
    input  wire logic [1:0]                   tx_rate_range_select_i,      // tx bit rate
    input  wire logic                         serial_clock_bypass_enable_i, // diag bit clock
    input  wire logic                         control_word_select_i,       // send control
    input  wire logic                         data_valid_in_i,             // send data
    input  wire logic                         flag_in_i,                   // flag bit
    input  wire logic [slwc_pkg::W_BITS-1:0]  tx_word_i,                   // parallel word
    input  wire logic                         tx_flag_enable_i,            // flag as data
    input  wire logic                         rx_flag_enable_i,            // flag as data
    input  wire logic                         enhanced_simplex_enable_i,   // scramble flag
    input  wire logic [1:0]                   rx_rate_range_select_i,      // rx bit rate
    input  wire logic                         test_serial_clock_i,         // rx test clock
    input  wire logic                         rx_reference_clock_i,        // rx reference
    input  wire logic                         alignment_disable_i,         // no bit slips
    input  wire logic [1:0]                   serial_input_pair_i,         // [1] p, [0] n
    output logic                              tx_serial_o,                 // serial line out
    output logic                              tx_locked_o,                 // tx lock
    output logic [slwc_pkg::W_BITS-1:0]       rx_word_o,                   // received word
    output logic                              rx_flag_o,                   // received flag
    output logic                              rx_data_o,                   // data word seen
    output logic                              control_word_indication_o,   // control word
    output logic                              rx_error_o,                  // decode error
    output logic                              rx_word_strobe_o,            // new word pulse
    output logic                              rx_slip_o,                   // slip pulse
    output logic                              link_ready_out_o,            // link ready
    output logic [1:0]                        recovered_word_clocks_o,     // [1] clk1, [0] clk0
    output logic                              rx_freq_lock_o               // reference lock
);
    import slwc_pkg::*;

    typedef struct packed {
        logic [1:0]        tdiv;    // tx rate divider
        logic [4:0]        tbit;    // tx bit index
        logic [19:0]       tsh;     // tx shift register
        logic              tser;    // serial output bit
        logic signed [6:0] acc;     // running disparity
        logic              talt;    // alternating flag
        logic              tclk_d;  // last word clock level
        logic              locked;  // tx lock
        logic [1:0]        rdiv;    // rx rate divider
        logic [4:0]        rbit;    // rx bit index
        logic [19:0]       rsh;     // rx shift register
        logic              slip_p;  // slip waiting for next bit
        logic              tst_d;   // last test clock level
        logic              ref_d;   // last reference level
        logic [2:0]        refcnt;  // reference edges seen
        logic              flock;   // frequency lock
        logic [1:0]        errcnt;  // consecutive errors
        logic [5:0]        win;     // words without flag transition
        logic              sflast;  // last line flag
        logic [1:0]        ralt;    // {seen, value} of last flag
        logic [6:0]        rdycnt;  // quiet words
        logic              ready;   // link ready
        logic [15:0]       rword;   // word out
        logic              rflag;   // flag out
        logic              rdata;   // data word
        logic              rctrl;   // control word
        logic              rerr;    // error
        logic              rstb;    // word strobe
        logic              rslip;   // slip pulse
        logic [1:0]        wclk;    // word clocks
    } slwc_state_s;

    slwc_state_s q;                 // registered state
    slwc_state_s d;                 // next state

    logic tscr_step;                // tx scrambler advance
    logic tscr_in;                  // tx plain flag
    logic tscr_out;                 // tx scrambled flag
    logic rscr_step;                // rx descrambler advance
    logic rscr_in;                  // rx line flag
    logic rscr_out;                 // rx plain flag

    // elaboration check: the 7-bit quiet counter cannot hold a wait of 128
    if (READY_WORDS < slwc_pkg::READY_WORDS || READY_WORDS >= READY_MAX) begin : g_bad_ready
        $error("ready wait must lie within 64 to 127 words");
    end

    // bit enable from a free-running divider; same code meaning at both ends
    function automatic logic bit_hit(input logic [1:0] sel, input logic [1:0] cnt);
        logic h;
        h = 1'b0;
        unique case (sel)
            RATE_DIV1: h = 1'b1;
            RATE_DIV2: h = cnt[0];
            RATE_DIV4: h = (cnt == 2'h3);
            default:   h = 1'b0;
        endcase
        return h;
    endfunction

    // disparity of an encoded word: ones minus zeros
    function automatic logic signed [6:0] disparity(input logic [19:0] w);
        logic [6:0] ones;
        ones = 7'h00;
        for (int i = 0; i < WORD_BITS; i++) begin
            ones = ones + 7'(w[i]);
        end
        return signed'(7'(ones + ones)) - 7'sd20;
    endfunction

    slwc_flag_scrambler #(.DESCRAMBLE(1'b0)) u_tx_scr (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .step_i     (tscr_step),
        .bit_i      (tscr_in),
        .bit_o      (tscr_out)
    );

    slwc_flag_scrambler #(.DESCRAMBLE(1'b1)) u_rx_scr (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .step_i     (rscr_step),
        .bit_i      (rscr_in),
        .bit_o      (rscr_out)
    );

    // all next-state logic of both link halves except the two flag scramblers
    always_comb begin
        logic              ten, tedge, tload, ren, rdone, slip, alt_err;
        logic [3:0]        cf, cn;
        logic [15:0]       wf;
        logic [19:0]       enc, rnext;
        logic signed [6:0] disp;
        logic              inv;
        slwc_kind_e        kind;
        ten = 1'b0; tedge = 1'b0; tload = 1'b0; ren = 1'b0; rdone = 1'b0;
        slip = 1'b0; alt_err = 1'b0; cf = C_IDLE; cn = C_IDLE; wf = IDLE_W;
        enc = '0; rnext = '0; disp = '0; inv = 1'b0; kind = K_IDLE;
        d = q;
        d.rstb  = 1'b0;
        d.rslip = 1'b0;

        // ---------------- transmit half ----------------
        d.tdiv   = q.tdiv + 2'h1;
        d.tclk_d = tx_word_clock_i;
        tedge    = tx_word_clock_i & ~q.tclk_d;
        // diagnostic bypass clocks bits straight from the word clock pin
        ten      = serial_clock_bypass_enable_i ? tedge
                 : bit_hit(tx_rate_range_select_i, q.tdiv);
        tload    = ten && (q.tbit == WORD_LAST);
        // plain flag source: user flag, or alternating when unused
        tscr_in  = tx_flag_enable_i ? flag_in_i : q.talt;
        tscr_step = tload && !control_word_select_i && data_valid_in_i
                  && enhanced_simplex_enable_i;
        if (control_word_select_i) begin
            cf = C_CTRL;
            wf = {CTRL_MARK, tx_word_i[CTRL_BITS-1:0]};
        end else if (data_valid_in_i) begin
            // scrambled flag only in enhanced mode
            cf = (enhanced_simplex_enable_i ? tscr_out : tscr_in)
               ? C_DATA1 : C_DATA0;
            wf = tx_word_i;
        end
        // neither select: idle word keeps the line balanced
        enc  = {cf, wf};
        disp = disparity(enc);
        // invert when word and history lean the same way
        inv  = (q.acc > 0 && disp > 0) || (q.acc < 0 && disp < 0);
        if (ten) begin
            d.tbit = (q.tbit == WORD_LAST) ? 5'h00 : q.tbit + 5'h01;
            d.tsh  = {1'b0, q.tsh[19:1]};
            if (tload) begin
                d.tsh = inv ? ~enc : enc;
                d.acc = inv ? q.acc - disp : q.acc + disp;
                if (!control_word_select_i && data_valid_in_i) begin
                    d.talt = ~q.talt;
                end
            end
            d.tser = d.tsh[0];
        end
        // lock: each word clock edge must land one bit before a load, so the
        // word starts right after the edge; otherwise realign the bit index
        if (serial_clock_bypass_enable_i) begin
            d.locked = 1'b0;
        end else if (tedge) begin
            d.locked = (d.tbit == WORD_LAST);
            if (d.tbit != WORD_LAST) begin
                d.tbit = WORD_LAST;
            end
        end

        // ---------------- receive half ----------------
        d.rdiv  = q.rdiv + 2'h1;
        d.tst_d = test_serial_clock_i;
        d.ref_d = rx_reference_clock_i;
        // frequency lock follows the reference alone, with or without input
        if (rx_reference_clock_i && !q.ref_d && !q.flock) begin
            d.refcnt = q.refcnt + 3'h1;
            d.flock  = (q.refcnt + 3'h1 == REF_LOCK_CNT);
        end
        ren = (rx_rate_range_select_i == RATE_BYPASS)
            ? (test_serial_clock_i & ~q.tst_d)
            : bit_hit(rx_rate_range_select_i, q.rdiv);
        rnext = {serial_input_pair_i[1] & ~serial_input_pair_i[0], q.rsh[19:1]};
        if (ren) begin
            d.rsh = rnext;
            if (q.slip_p) begin
                d.slip_p = 1'b0;
            end else begin
                rdone  = (q.rbit == WORD_LAST);
                d.rbit = rdone ? 5'h00 : q.rbit + 5'h01;
            end
        end
        d.wclk = (d.rbit < WORD_HALF) ? 2'b10 : 2'b01;
        // split fields and undo inversion
        cf   = rnext[19:16];
        cn   = slwc_is_inv(cf) ? ~cf : cf;
        wf   = slwc_is_inv(cf) ? ~rnext[15:0] : rnext[15:0];
        kind = slwc_classify(cn);
        rscr_in   = (cn == C_DATA1);
        rscr_step = rdone && kind == K_DATA && enhanced_simplex_enable_i;
        // alternation check when flag carries no user data and enhanced mode is off
        alt_err = kind == K_DATA && !enhanced_simplex_enable_i && !rx_flag_enable_i
                && q.ralt[1] && (q.ralt[0] == rscr_in);
        if (rdone) begin
            d.rstb  = 1'b1;
            d.rdata = (kind == K_DATA);
            d.rctrl = (kind == K_CTRL);
            d.rerr  = (kind == K_ERR) || alt_err;
            d.rword = (kind == K_CTRL) ? {2'b00, wf[CTRL_BITS-1:0]} : wf;
            if (kind == K_DATA) begin
                d.rflag = enhanced_simplex_enable_i ? rscr_out : rscr_in;
                d.ralt  = {1'b1, rscr_in};
            end
            d.errcnt = d.rerr ? q.errcnt + 2'h1 : 2'h0;
            if (d.rerr && q.errcnt + 2'h1 == ERR_SLIP_CNT) begin
                slip = 1'b1;
            end
            if (enhanced_simplex_enable_i && kind == K_DATA) begin
                d.sflast = rscr_in;
                d.win    = (rscr_in != q.sflast) ? 6'h00 : q.win + 6'h01;
                if (rscr_in == q.sflast && q.win + 6'h01 == 6'(FLAG_WINDOW)) begin
                    slip = 1'b1;
                end
            end
            if (q.rdycnt != 7'(READY_WORDS)) begin
                d.rdycnt = q.rdycnt + 7'h01;
            end
            d.ready = q.ready || (q.rdycnt + 7'h01 == 7'(READY_WORDS));
            if (slip && !alignment_disable_i) begin
                d.slip_p = 1'b1;
                d.rslip  = 1'b1;
                d.ready  = 1'b0;
                d.errcnt = 2'h0;
                d.win    = 6'h00;
                d.rdycnt = 7'h00;
            end
        end
    end

    // single state register; reset also restarts word alignment
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q      <= '0;
            q.wclk <= 2'b10;
        end else begin
            q <= d;
        end
    end

    // every output is a flip-flop of the state
    assign tx_serial_o               = q.tser;
    assign tx_locked_o               = q.locked;
    assign rx_word_o                 = q.rword;
    assign rx_flag_o                 = q.rflag;
    assign rx_data_o                 = q.rdata;
    assign control_word_indication_o = q.rctrl;
    assign rx_error_o                = q.rerr;
    assign rx_word_strobe_o          = q.rstb;
    assign rx_slip_o                 = q.rslip;
    assign link_ready_out_o          = q.ready;
    assign recovered_word_clocks_o   = q.wclk;
    assign rx_freq_lock_o            = q.flock;
endmodule

// ### testbench/slwc_codec_chk.sv
// port assertions for the word codec
`timescale 1ns/1ns
module slwc_codec_chk #(
    parameter int READY_WORDS = 64                        // quiet words before ready
) (
    input wire logic                        core_clk_i,                   // clock
    input wire logic                        resetn_i,                     // reset, low
    input wire logic                        serial_clock_bypass_enable_i, // diag clock
    input wire logic                        alignment_disable_i,          // no slips
    input wire logic                        tx_locked_o,                  // tx lock
    input wire logic [slwc_pkg::W_BITS-1:0] rx_word_o,                    // word
    input wire logic                        control_word_indication_o,    // control
    input wire logic                        rx_word_strobe_o,             // word pulse
    input wire logic                        rx_slip_o,                    // slip pulse
    input wire logic                        link_ready_out_o,             // ready
    input wire logic [1:0]                  recovered_word_clocks_o,      // word clocks
    input wire logic                        rx_freq_lock_o                // ref lock
);
    logic [7:0] quiet_q;  // strobes since reset or slip
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // saturates so a long quiet run cannot wrap into the ready window
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            quiet_q <= 8'h00;
        end else if (rx_slip_o) begin
            quiet_q <= 8'h00;
        end else if (rx_word_strobe_o && quiet_q != 8'hFF) begin
            quiet_q <= quiet_q + 8'h01;
        end
    end
    a_strobe_one_cycle: assert property (rx_word_strobe_o |=> !rx_word_strobe_o)
        else $error("word strobe longer than one cycle");
    a_slip_with_strobe: assert property (rx_slip_o |-> rx_word_strobe_o)
        else $error("slip without word strobe");
    a_slip_drops_ready: assert property (rx_slip_o |-> !link_ready_out_o)
        else $error("ready held through a slip");
    a_slip_when_disabled: assert property (rx_slip_o |-> !$past(alignment_disable_i))
        else $error("slip while alignment disabled");
    a_word_clocks_compl: assert property (recovered_word_clocks_o[0] != recovered_word_clocks_o[1])
        else $error("word clocks not complementary");
    a_freq_lock_holds: assert property (rx_freq_lock_o |=> rx_freq_lock_o)
        else $error("frequency lock lost");
    a_ready_rise_count: assert property ($rose(link_ready_out_o) |-> rx_word_strobe_o
        && quiet_q >= READY_WORDS - 1 && quiet_q <= 127)
        else $error("ready rose outside the quiet window");
    a_ctrl_top_clear: assert property (control_word_indication_o |-> rx_word_o[15:14] == 2'h0)
        else $error("control word carries high bits");
    a_bypass_unlocks: assert property (serial_clock_bypass_enable_i |=> !tx_locked_o)
        else $error("locked while clock bypassed");
endmodule

// ### testbench/slwc_far_end.sv
// far-end model: word clock, reference clock and line loopback
`timescale 1ns/1ns
module slwc_far_end (
    input  wire logic       core_clk_i, // bench clock
    input  wire logic       line_i,     // serial bit from the codec
    output logic            word_clk_o, // word clock, 20 cycles a period
    output logic            ref_clk_o,  // receive reference clock
    output logic [1:0]      pair_o      // line pair, p then n
);
    int cnt = 0;  // cycle within a word period
    initial {word_clk_o, ref_clk_o} = 2'h0;
    // one word clock per 20 bits at rate range zero
    always @(negedge core_clk_i) begin
        cnt = (cnt + 1) % 20;
        word_clk_o <= (cnt < 10);
        ref_clk_o <= cnt[1];
    end
    assign pair_o = {line_i, ~line_i};  // the receiver takes p and not n
endmodule

// ### testbench/tb_top.sv
// loopback bench for the word codec
`timescale 1ns/1ns
module tb_top;
    import slwc_pkg::*;
    logic core_clk_i = 1'b0, resetn_i, tx_word_clock_i, serial_clock_bypass_enable_i;
    logic control_word_select_i, data_valid_in_i, flag_in_i, tx_flag_enable_i;
    logic rx_flag_enable_i, enhanced_simplex_enable_i, test_serial_clock_i = 1'b0;
    logic rx_reference_clock_i, alignment_disable_i, tx_serial_o, tx_locked_o, rx_flag_o;
    logic rx_data_o, control_word_indication_o, rx_error_o, rx_word_strobe_o, rx_slip_o;
    logic link_ready_out_o, rx_freq_lock_o;
    logic [1:0] tx_rate_range_select_i, rx_rate_range_select_i, serial_input_pair_i;
    logic [1:0] recovered_word_clocks_o;
    logic [15:0] tx_word_i, rx_word_o;
    int num_errors = 0, checks_done = 0, cycles = 0, i;
    always #10 core_clk_i = ~core_clk_i;
    slwc_codec DUT (.*);
    slwc_far_end u_far (.core_clk_i(core_clk_i), .line_i(tx_serial_o),
        .word_clk_o(tx_word_clock_i), .ref_clk_o(rx_reference_clock_i),
        .pair_o(serial_input_pair_i));
    task automatic results();
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic strobe();
        do begin @(posedge core_clk_i); #1; end while (rx_word_strobe_o !== 1'b1);
    endtask
    // hold one word kind; skip three decoded words, then check each of the next n against the inputs
    task automatic run(input logic c, input logic d, input int n);
        @(negedge core_clk_i);
        {control_word_select_i, data_valid_in_i} = {c, d};
        tx_word_i = 16'($urandom);
        flag_in_i = 1'($urandom);
        repeat (3) strobe();
        repeat (n) begin
            strobe();
            check(rx_error_o, 1'b0);
            check(rx_data_o, d && !c);
            check(control_word_indication_o, c);
            if (c || d) check(rx_word_o, c ? {2'h0, tx_word_i[13:0]} : tx_word_i);
            if (d && !c && tx_flag_enable_i) check(rx_flag_o, flag_in_i);
        end
    endtask
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        resetn_i = 1'b0;
        tx_rate_range_select_i = RATE_DIV1;
        rx_rate_range_select_i = RATE_DIV1;
        {serial_clock_bypass_enable_i, control_word_select_i, flag_in_i} = 3'h0;
        {tx_flag_enable_i, rx_flag_enable_i, enhanced_simplex_enable_i} = 3'h0;
        {alignment_disable_i, data_valid_in_i, tx_word_i} = {2'h1, 16'h0000};
        void'($urandom(10788));
        repeat (16) @(posedge core_clk_i);
        @(negedge core_clk_i) resetn_i = 1'b1;
        // alternating flag makes misaligned words decode as errors
        for (i = 0; i < 9000 && link_ready_out_o !== 1'b1; i++) begin
            @(negedge core_clk_i) tx_word_i = 16'($urandom);
        end
        check(link_ready_out_o, 1'b1);
        check(tx_locked_o, 1'b1);
        check(rx_freq_lock_o, 1'b1);
        run(1'b0, 1'b1, 4);
        @(negedge core_clk_i) {tx_flag_enable_i, rx_flag_enable_i} = 2'h3;
        for (i = 0; i < 6; i++) begin
            @(negedge core_clk_i) enhanced_simplex_enable_i = i[0];
            run(1'b0, 1'b1, 5);
            run(1'b1, i[1], 3);
            run(1'b0, 1'b0, 3);
        end
        @(negedge core_clk_i) alignment_disable_i = 1'b1;
        run(1'b0, 1'b1, 4);
        // constant flag with the alternation check on: each data word fails, yet no slip
        @(negedge core_clk_i) {enhanced_simplex_enable_i, rx_flag_enable_i} = 2'h0;
        repeat (5) strobe();
        check(rx_error_o, 1'b1);
        check(link_ready_out_o, 1'b1);
        @(negedge core_clk_i) serial_clock_bypass_enable_i = 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1 check(tx_locked_o, 1'b0);
        results();
    end
endmodule
bind slwc_codec slwc_codec_chk #(.READY_WORDS(READY_WORDS)) u_chk (.*);
